/* File: inc/tfm_pkg.sv */
// shared constants and carrier types for the traverse frequency modulator
// assumes a single 20 MHz clock; percentages are held in 0.1 % units, times in 0.1 s units
package tfm_pkg;
   // application function selector codes
   localparam logic [2:0] APP_NONE  = 3'h0;
   localparam logic [2:0] APP_SWEEP = 3'h1;
   localparam logic [2:0] APP_PID   = 3'h2;
   localparam logic [2:0] APP_RSVD  = 3'h3;
   localparam logic [2:0] APP_AUTO  = 3'h4;

   // input terminal function codes
   localparam logic [6:0] FN_LOW_OFFSET  = 7'h1b;
   localparam logic [6:0] FN_HIGH_OFFSET = 7'h1c;
   localparam int         NUM_TERMINALS  = 11;

   // setting limits and reset values
   localparam logic [9:0]  PCT_SCALE = 10'h3e8;
   localparam logic [7:0]  AMP_MAX   = 8'hc8;
   localparam logic [7:0]  AMP_RST   = 8'h00;
   localparam logic [8:0]  SCR_MAX   = 9'h1f4;
   localparam logic [8:0]  SCR_RST   = 9'h000;
   localparam logic [12:0] TIME_MIN  = 13'h0001;
   localparam logic [12:0] TIME_MAX  = 13'h1770;
   localparam logic [12:0] ACC_RST   = 13'h0014;
   localparam logic [12:0] DEC_RST   = 13'h001e;
   localparam logic [7:0]  OFS_MAX   = 8'hc8;
   localparam logic [7:0]  OFS_RST   = 8'h00;

   // ramp time unit and its length in clock cycles
   localparam int CLK_PERIOD_NS   = 50;
   localparam int TIME_UNIT_NS    = 100000000;
   localparam int CYC_PER_UNIT    = TIME_UNIT_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0]  amplitude_pct;
      logic [8:0]  scramble_pct;
      logic [12:0] acc_time;
      logic [12:0] dec_time;
      logic [7:0]  high_offset_pct;
      logic [7:0]  low_offset_pct;
   } tfm_settings_t;

   localparam tfm_settings_t SETTINGS_RST = '{AMP_RST, SCR_RST, ACC_RST, DEC_RST, OFS_RST, OFS_RST};

   typedef logic [NUM_TERMINALS-1:0][6:0] tfm_term_func_t;

   typedef enum logic {TFM_RISE, TFM_FALL} tfm_phase_t;
endpackage : tfm_pkg

/* File: core/tfm_sync.sv */
// two-stage synchroniser for asynchronous level inputs
// assumes levels stay put well beyond two clock periods
`timescale 1ns/1ps
module tfm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,   // system clock
   input  wire logic             rst_b,  // async reset, active low
   input  wire logic [WIDTH-1:0] d,      // asynchronous levels
   output logic      [WIDTH-1:0] q       // synchronised levels
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule : tfm_sync

/* File: core/tfm_modulator.sv */
// traverse frequency modulator: triangular sweep around the frequency reference
// assumes freq_ref, settings and app_mode are synchronous to mclk; terminal pins are asynchronous
//
// Contract
// - selector codes 0..4; sweep and its settings act only under code 1
// - hold sweep amplitude 0..20 %, default 0, as share of reference
// - at each deceleration start jump down by scramble 0..50 % of amplitude
// - rise over acceleration time, fall over deceleration time, 0.1..600 s
// - hold high offset 0..20 %, default 0, as share of reference
// - while a code-28 terminal is on add the high offset
// - hold low offset 0..20 %, default 0, as share of reference
// - while a code-27 terminal is on subtract the low offset
// - each of eleven terminals takes its function from its own setting
`timescale 1ns/1ps
module tfm_modulator #(
   parameter int CYC_PER_UNIT = tfm_pkg::CYC_PER_UNIT
) (
   input  wire logic                   mclk,          // 20 MHz system clock
   input  wire logic                   rst_b,         // async reset, active low
   input  wire logic [2:0]             app_mode,      // application function selector
   input  wire logic [15:0]            freq_ref,      // frequency reference, 0.01 Hz
   input  wire logic                   settings_wr,   // one-cycle strobe to take settings_in
   input  wire tfm_pkg::tfm_settings_t settings_in,   // new sweep settings
   input  wire tfm_pkg::tfm_term_func_t input_terminal_function, // per-terminal function codes
   input  wire logic [10:0]            terminal_pin,  // input terminal levels, asynchronous
   output logic [15:0]                 freq_cmd,      // frequency command to the drive
   output logic                        sweep_active,  // sweep function running
   output logic                        sweep_falling, // sweep in its falling phase
   output tfm_pkg::tfm_settings_t      settings_out   // settings held now
);
   tfm_pkg::tfm_settings_t set_reg, set_next;
   tfm_pkg::tfm_phase_t    phase_reg, phase_next;
   logic signed [17:0]     pos_reg, pos_next;
   logic [34:0]            err_reg, err_next;
   logic [15:0]            freq_reg, freq_next;
   logic                   active_reg, active_next;
   logic [10:0]            term_level;
   logic                   hi_on, lo_on, sweep_sel;
   logic [23:0]            amp_f, hi_f, lo_f;
   logic [24:0]            scr_f;
   logic signed [17:0]     amp_s, scr_s, jump_pos;
   logic [16:0]            span;
   logic [34:0]            n_acc, n_dec;
   logic [35:0]            err_sum;
   logic signed [19:0]     sum;

   tfm_sync #(.WIDTH(11)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (terminal_pin),
      .q     (term_level)
   );

   // settings store, clamped into range on write
   always_comb begin
      set_next = set_reg;
      if (settings_wr) begin
         set_next = settings_in;
         if (settings_in.amplitude_pct > tfm_pkg::AMP_MAX) set_next.amplitude_pct = tfm_pkg::AMP_MAX;
         if (settings_in.scramble_pct > tfm_pkg::SCR_MAX) set_next.scramble_pct = tfm_pkg::SCR_MAX;
         if (settings_in.acc_time < tfm_pkg::TIME_MIN) set_next.acc_time = tfm_pkg::TIME_MIN;
         if (settings_in.acc_time > tfm_pkg::TIME_MAX) set_next.acc_time = tfm_pkg::TIME_MAX;
         if (settings_in.dec_time < tfm_pkg::TIME_MIN) set_next.dec_time = tfm_pkg::TIME_MIN;
         if (settings_in.dec_time > tfm_pkg::TIME_MAX) set_next.dec_time = tfm_pkg::TIME_MAX;
         if (settings_in.high_offset_pct > tfm_pkg::OFS_MAX) set_next.high_offset_pct = tfm_pkg::OFS_MAX;
         if (settings_in.low_offset_pct > tfm_pkg::OFS_MAX) set_next.low_offset_pct = tfm_pkg::OFS_MAX;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         set_reg <= tfm_pkg::SETTINGS_RST;
      end else begin
         set_reg <= set_next;
      end
   end

   // terminal function decode
   always_comb begin
      hi_on = 1'b0;
      lo_on = 1'b0;
      for (int i = 0; i < tfm_pkg::NUM_TERMINALS; i++) begin
         if (term_level[i] && input_terminal_function[i] == tfm_pkg::FN_HIGH_OFFSET) hi_on = 1'b1;
         if (term_level[i] && input_terminal_function[i] == tfm_pkg::FN_LOW_OFFSET) lo_on = 1'b1;
      end
   end

   // frequency amounts derived from the reference
   assign sweep_sel = (app_mode == tfm_pkg::APP_SWEEP);
   assign amp_f     = (freq_ref * set_reg.amplitude_pct) / tfm_pkg::PCT_SCALE;
   assign scr_f     = (amp_f[15:0] * set_reg.scramble_pct) / tfm_pkg::PCT_SCALE;
   assign hi_f      = (freq_ref * set_reg.high_offset_pct) / tfm_pkg::PCT_SCALE;
   assign lo_f      = (freq_ref * set_reg.low_offset_pct) / tfm_pkg::PCT_SCALE;
   assign amp_s     = $signed({2'b00, amp_f[15:0]});
   assign scr_s     = $signed({2'b00, scr_f[15:0]});
   assign jump_pos  = (amp_s - scr_s < -amp_s) ? -amp_s : amp_s - scr_s;
   assign span      = {amp_f[15:0], 1'b0};
   assign n_acc     = 35'(set_reg.acc_time) * 35'(CYC_PER_UNIT);
   assign n_dec     = 35'(set_reg.dec_time) * 35'(CYC_PER_UNIT);

   // sweep position: spread 2*amp evenly over the ramp time, one step at most per cycle
   always_comb begin
      phase_next = phase_reg;
      pos_next   = pos_reg;
      err_next   = err_reg;
      err_sum    = {1'b0, err_reg} + 36'(span);
      if (!sweep_sel) begin
         phase_next = tfm_pkg::TFM_RISE;
         pos_next   = -amp_s;
         err_next   = '0;
      end else begin
         case (phase_reg)
            tfm_pkg::TFM_RISE: begin
               if (pos_reg >= amp_s) begin
                  phase_next = tfm_pkg::TFM_FALL;
                  pos_next   = jump_pos;
                  err_next   = '0;
               end else if (err_sum >= 36'(n_acc)) begin
                  pos_next = pos_reg + 18'sh00001;
                  err_next = 35'(err_sum - 36'(n_acc));
               end else begin
                  err_next = err_sum[34:0];
               end
            end
            tfm_pkg::TFM_FALL: begin
               if (pos_reg <= -amp_s) begin
                  phase_next = tfm_pkg::TFM_RISE;
                  err_next   = '0;
               end else if (err_sum >= 36'(n_dec)) begin
                  pos_next = pos_reg - 18'sh00001;
                  err_next = 35'(err_sum - 36'(n_dec));
               end else begin
                  err_next = err_sum[34:0];
               end
            end
            default: begin
               phase_next = tfm_pkg::TFM_RISE;
               pos_next   = -amp_s;
               err_next   = '0;
            end
         endcase
      end
   end

   // command: sweep plus any offsets that are on, clamped to the output range
   always_comb begin
      sum = 20'(freq_ref) + 20'(pos_reg);
      if (hi_on) sum = sum + 20'(hi_f[15:0]);
      if (lo_on) sum = sum - 20'(lo_f[15:0]);
      if (!sweep_sel) freq_next = freq_ref;
      else if (sum < 20'sh00000) freq_next = 16'h0000;
      else if (sum > 20'sh0ffff) freq_next = 16'hffff;
      else freq_next = sum[15:0];
      active_next = sweep_sel;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg  <= tfm_pkg::TFM_RISE;
         pos_reg    <= '0;
         err_reg    <= '0;
         freq_reg   <= '0;
         active_reg <= 1'b0;
      end else begin
         phase_reg  <= phase_next;
         pos_reg    <= pos_next;
         err_reg    <= err_next;
         freq_reg   <= freq_next;
         active_reg <= active_next;
      end
   end

   assign freq_cmd      = freq_reg;
   assign sweep_active  = active_reg;
   assign sweep_falling = (phase_reg == tfm_pkg::TFM_FALL);
   assign settings_out  = set_reg;

   passthrough_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !sweep_sel |=> freq_cmd == $past(freq_ref))
      else $error("reference not passed through outside sweep");

   mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      app_mode != tfm_pkg::APP_SWEEP |=> !sweep_active && !sweep_falling)
      else $error("sweep running under another function code");

   rise_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sweep_sel && phase_reg == tfm_pkg::TFM_RISE && pos_reg < amp_s ##1 sweep_sel
      |-> pos_reg - $past(pos_reg) inside {18'sh00000, 18'sh00001})
      else $error("rising sweep moved by more than one step");

   fall_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sweep_sel && phase_reg == tfm_pkg::TFM_FALL && pos_reg > -amp_s ##1 sweep_sel
      |-> $past(pos_reg) - pos_reg inside {18'sh00000, 18'sh00001})
      else $error("falling sweep moved by more than one step");

   scramble_jump_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sweep_sel && phase_reg == tfm_pkg::TFM_RISE && pos_reg >= amp_s
      |=> phase_reg == tfm_pkg::TFM_FALL && pos_reg == $past(jump_pos) && pos_reg <= $past(amp_s))
      else $error("deceleration did not start with the scramble jump");

   setting_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
      set_reg.amplitude_pct <= tfm_pkg::AMP_MAX && set_reg.scramble_pct <= tfm_pkg::SCR_MAX &&
      set_reg.high_offset_pct <= tfm_pkg::OFS_MAX && set_reg.low_offset_pct <= tfm_pkg::OFS_MAX)
      else $error("stored percentage out of range");

   time_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
      set_reg.acc_time inside {[tfm_pkg::TIME_MIN:tfm_pkg::TIME_MAX]} &&
      set_reg.dec_time inside {[tfm_pkg::TIME_MIN:tfm_pkg::TIME_MAX]})
      else $error("stored ramp time out of range");

   high_offset_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sweep_sel && hi_on && !lo_on
      && $signed(20'(freq_ref) + 20'(pos_reg) + 20'(hi_f[15:0])) <= 20'sh0ffff
      && $signed(20'(freq_ref) + 20'(pos_reg)) >= 20'sh00000
      |=> 20'(freq_cmd) == $past(20'(freq_ref) + 20'(pos_reg) + 20'(hi_f[15:0])))
      else $error("high offset not added");

   low_offset_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sweep_sel && lo_on && !hi_on
      && $signed(20'(freq_ref) + 20'(pos_reg) - 20'(lo_f[15:0])) >= 20'sh00000
      && $signed(20'(freq_ref) + 20'(pos_reg)) <= 20'sh0ffff
      |=> 20'(freq_cmd) == $past(20'(freq_ref) + 20'(pos_reg) - 20'(lo_f[15:0])))
      else $error("low offset not subtracted");
endmodule : tfm_modulator

/* File: tb/tfm_drive_model.sv */
// drive output stage model: takes the frequency command on every clock without clear and keeps its extremes
// assumes freq_cmd is registered on mclk; clear restarts the tracking
`timescale 1ns/1ps
module tfm_drive_model (
   input  wire logic        mclk,     // system clock
   input  wire logic        rst_b,    // async reset, active low
   input  wire logic        clear,    // restart min and max tracking
   input  wire logic [15:0] freq_cmd, // frequency command taken by the drive
   output logic      [15:0] min_seen, // lowest command since clear
   output logic      [15:0] max_seen  // highest command since clear
);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         min_seen <= 16'hffff;
         max_seen <= 16'h0000;
      end else if (clear) begin
         min_seen <= 16'hffff;
         max_seen <= 16'h0000;
      end else begin
         if (freq_cmd < min_seen) min_seen <= freq_cmd;
         if (freq_cmd > max_seen) max_seen <= freq_cmd;
      end
   end
endmodule : tfm_drive_model

/* File: tb/tb_top.sv */
// testbench for the traverse frequency modulator
// assumes a 20 MHz mclk and a shortened time unit of 100 cycles per 0.1 s
`timescale 1ns/1ps
module tb_top;
   localparam int CYC = 100;
   logic                   mclk = 1'b0;
   logic                   rst_b = 1'b0;
   logic [2:0]             app_mode = 3'h0;
   logic [15:0]            freq_ref = 16'h03e8;
   logic                   settings_wr = 1'b0;
   tfm_pkg::tfm_settings_t settings_in = '0;
   tfm_pkg::tfm_term_func_t term_fn = '0;
   logic [10:0]            terminal_pin = 11'h000;
   logic                   clear = 1'b0;
   logic [15:0]            freq_cmd, min_seen, max_seen;
   logic                   sweep_active, sweep_falling;
   tfm_pkg::tfm_settings_t settings_out;
   int                     failures = 0;
   int                     n_checks = 0;
   int                     n;

   initial forever #25 mclk = ~mclk;

   tfm_modulator #(.CYC_PER_UNIT(CYC)) tfm_modulator_inst (.mclk(mclk), .rst_b(rst_b), .app_mode(app_mode),
      .freq_ref(freq_ref), .settings_wr(settings_wr), .settings_in(settings_in), .input_terminal_function(term_fn),
      .terminal_pin(terminal_pin), .freq_cmd(freq_cmd), .sweep_active(sweep_active), .sweep_falling(sweep_falling),
      .settings_out(settings_out));
   tfm_drive_model tfm_drive_model_inst (.mclk(mclk), .rst_b(rst_b), .clear(clear), .freq_cmd(freq_cmd),
      .min_seen(min_seen), .max_seen(max_seen));

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic write_settings(input tfm_pkg::tfm_settings_t s);
      @(posedge mclk);
      settings_wr <= 1'b1;
      settings_in <= s;
      @(posedge mclk);
      settings_wr <= 1'b0;
      cyc(1);
   endtask : write_settings

   // counts cycles until the phase flag reaches lvl; a hang ends the run
   task automatic wait_phase(input logic lvl, output int cnt);
      cnt = 0;
      while (sweep_falling !== lvl) begin
         cyc(1);
         cnt++;
         if (cnt > 20000) begin
            failures++;
            complete_run();
         end
      end
   endtask : wait_phase

   task automatic restart_sweep;
      @(posedge mclk);
      app_mode <= tfm_pkg::APP_NONE;
      clear    <= 1'b1;
      cyc(3);
      @(posedge mclk);
      app_mode <= tfm_pkg::APP_SWEEP;
      clear    <= 1'b0;
      #1;
   endtask : restart_sweep

   initial begin
      static logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      cyc(3);
      check("settings_rst", settings_out, tfm_pkg::SETTINGS_RST);
      check("pass_rst", freq_cmd, 16'h03e8);
      write_settings('{8'h00, 9'h000, 13'h0014, 13'h001e, 8'h32, 8'h1e});
      @(posedge mclk);
      term_fn[3]   <= tfm_pkg::FN_HIGH_OFFSET;
      term_fn[9]   <= tfm_pkg::FN_LOW_OFFSET;
      term_fn[0]   <= 7'h26;
      terminal_pin <= 11'h7ff;
      foreach (modes[i]) begin
         @(posedge mclk);
         app_mode <= modes[i];
         cyc(4);
         check("pass_cmd", freq_cmd, 16'h03e8);
         check("pass_active", sweep_active, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         app_mode     <= tfm_pkg::APP_SWEEP;
         terminal_pin <= {1'b0, k[1], 5'b0, k[0], 2'b0, 1'b1};
         cyc(4);
         check("ofs_active", sweep_active, 1'b1);
         check("ofs_cmd", freq_cmd, 16'h03e8 + (k[0] ? 16'h0032 : 16'h0) - (k[1] ? 16'h001e : 16'h0));
      end
      write_settings('{8'hff, 9'h1ff, 13'h0000, 13'h1fff, 8'hff, 8'hc9});
      check("clamp", settings_out, {tfm_pkg::AMP_MAX, tfm_pkg::SCR_MAX, tfm_pkg::TIME_MIN, tfm_pkg::TIME_MAX,
            tfm_pkg::OFS_MAX, tfm_pkg::OFS_MAX});
      @(posedge mclk);
      terminal_pin <= 11'h000;
      // default ramp times: rise 2.0 s, fall 3.0 s in shortened units
      write_settings('{8'h0a, 9'h000, tfm_pkg::ACC_RST, tfm_pkg::DEC_RST, 8'h00, 8'h00});
      restart_sweep();
      wait_phase(1'b1, n);
      wait_phase(1'b0, n);
      check("fall_len", (n >= 30 * CYC - 3) && (n <= 30 * CYC + 3), 1'b1);
      wait_phase(1'b1, n);
      check("rise_len", (n >= 20 * CYC - 3) && (n <= 20 * CYC + 3), 1'b1);
      // amplitude 10 % and scramble 50 % of it
      write_settings('{8'h64, 9'h1f4, 13'h0001, 13'h0001, 8'h00, 8'h00});
      restart_sweep();
      wait_phase(1'b1, n);
      cyc(1);
      check("scramble", freq_cmd, 16'h041a);
      wait_phase(1'b0, n);
      wait_phase(1'b1, n);
      check("sweep_max", max_seen, 16'h044c);
      check("sweep_min", min_seen, 16'h0384);
      complete_run();
   end
endmodule : tb_top
